// ---- core/mlspm_pad_map.sv ----
// Purpose: Map controller lanes onto pads for one manager instance
// Assumes: Link-side lanes run on link_clk; registers on clk
// Notes:   Output enables are active high while the pad is driven
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "mlspm_params.svh"

module mlspm_pad_map
	import mlspm_pkg::*;
#(
	parameter int INSTANCE = 0
)
(
	// Clocks and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        link_clk,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	// Controller side, link domain
	input  wire logic        core_sck,
	input  wire logic        core_cs_active,
	input  wire logic [15:0] core_dout,
	input  wire logic [15:0] core_doe,
	output logic      [15:0] core_din,
	input  wire logic [1:0]  core_strobe_out,
	input  wire logic        core_strobe_oe,
	output logic      [1:0]  core_strobe_in,
	// Pads
	output logic             first_chip_select_b,
	output logic             second_chip_select_b,
	output logic             clk_pad_out,
	output logic             clk_pad_oe,
	input  wire logic [15:0] data_pad_in,
	output logic      [15:0] data_pad_out,
	output logic      [15:0] data_pad_oe,
	input  wire logic        low_data_strobe_in,
	output logic             low_data_strobe_out,
	output logic             low_data_strobe_oe,
	input  wire logic        high_data_strobe_in,
	output logic             high_data_strobe_out,
	output logic             high_data_strobe_oe
);

	// Only four instances exist; any other index is refused at elaboration
	if (INSTANCE < 0 || INSTANCE > 3)
	begin : g_instance_check
		$error("mlspm_pad_map: INSTANCE must be 0 to 3");
	end

	// Hex capability of this instance
	localparam logic HEX_OK = (INSTANCE == 0) || (INSTANCE == 3);

	////////////////////////////////////////////////////////////////////////
	// Register domain state
	typedef struct packed
	{
		logic [2:0]  mode;       // Width after capability check
		logic        cs_sel;     // Second device chosen
		logic        clk4;       // Clock relocation
		logic        sepio;      // Separate input select
		logic [16:0] oemask;     // Pad output enable mask
		logic [31:0] rdata;      // Read data
	} mlspm_reg_t;

	mlspm_reg_t r;       // Registered state
	mlspm_reg_t next_r;  // Next state
	logic [16:0] lane_en_status; // Computed lane use, register side

	// Legal mode after capability check
	function automatic mlspm_mode_t legal_mode(input logic [2:0] m);
		if (m == 3'(mlspm_hex) && HEX_OK)
			legal_mode = mlspm_hex;
		else if (m <= 3'(mlspm_octal))
			legal_mode = mlspm_mode_t'(m);
		else
			legal_mode = mlspm_single;
	endfunction

	// Register next-state logic
	always_comb
	begin
		next_r = r;
		next_r.rdata = 32'h0000_0000;
		if (reg_write)
		begin
			unique case (reg_addr)
				`MLSPM_ADDR_CFG:
				begin
					next_r.mode = 3'(legal_mode(
						reg_wdata[`MLSPM_CFG_MODE_MSB:`MLSPM_CFG_MODE_LSB]));
					next_r.cs_sel = reg_wdata[`MLSPM_CFG_CS_BIT];
					next_r.clk4 = reg_wdata[`MLSPM_CFG_CLK4_BIT];
					next_r.sepio = reg_wdata[`MLSPM_CFG_SEPIO_BIT];
				end
				`MLSPM_ADDR_OEMASK:
					next_r.oemask = reg_wdata[16:0];
				default:
				begin
					// Unmapped write is ignored
				end
			endcase
		end
		if (reg_read)
		begin
			unique case (reg_addr)
				`MLSPM_ADDR_CFG:
					next_r.rdata = {26'h0, r.sepio, r.clk4, r.cs_sel, r.mode};
				`MLSPM_ADDR_OEMASK:
					next_r.rdata = {15'h0, r.oemask};
				`MLSPM_ADDR_STATUS:
					next_r.rdata = {15'h0, lane_en_status};
				default:
					next_r.rdata = 32'h0000_0000;
			endcase
		end
	end

	// Register update
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			r <= '0;
		else
			r <= next_r;
	end

	assign reg_rdata = r.rdata;

	////////////////////////////////////////////////////////////////////////
	// Crossing of static configuration into the link domain
	// The configuration word is many bits wide, so two flip-flops alone could
	// hand the link logic a mix of old and new bits for one cycle. A third
	// stage is compared with the second, and the word is adopted only once
	// two successive samples agree. Software must leave the configuration
	// still while a transfer runs; a change costs about four link cycles.
	// Pad inputs come from outside either domain and pass two flip-flops
	// before any steering logic looks at them.
	typedef struct packed
	{
		logic [22:0] sync1;    // First stage, read only by second
		logic [22:0] sync2;    // Second stage
		logic [22:0] sync3;    // Third stage, compared with second
		logic [22:0] cfg;      // Configuration adopted by the link logic
		logic [15:0] pad_s1;   // Data pad inputs, first stage
		logic [15:0] pad_s2;   // Data pad inputs, second stage
		logic [1:0]  strb_s1;  // Strobe pad inputs, first stage
		logic [1:0]  strb_s2;  // Strobe pad inputs, second stage
		logic [15:0] din;      // Sampled input data
		logic [1:0]  strb;     // Sampled strobes
	} mlspm_link_t;

	mlspm_link_t l;       // Link state
	mlspm_link_t next_l;  // Next link state

	// Configuration word carried across
	logic [22:0] cfg_word;
	assign cfg_word = {r.oemask, r.sepio, r.clk4, r.cs_sel, r.mode};

	// Fields seen by the link logic
	logic [2:0]  lk_mode;
	logic        lk_cs;
	logic        lk_clk4;
	logic        lk_sepio;
	logic [16:0] lk_mask;
	assign {lk_mask, lk_sepio, lk_clk4, lk_cs, lk_mode} = l.cfg;

	// Lanes a configuration may drive; bit 16 is the clock pad
	function automatic logic [16:0] lanes_used(input logic [2:0] m,
		input logic cs, input logic c4);
		logic [15:0] d;
		d = 16'h0000;
		unique case (mlspm_mode_t'(m))
			mlspm_single: d = cs ? 16'h0010 : 16'h0001;
			mlspm_dual:   d = cs ? 16'h0030 : 16'h0003;
			mlspm_quad:   d = cs ? 16'h00f0 : 16'h000f;
			mlspm_octal:  d = 16'h00ff;
			mlspm_hex:    d = 16'hffff;
			default:      d = 16'h0000;
		endcase
		if (c4 && m != 3'(mlspm_octal) && m != 3'(mlspm_hex))
			lanes_used = {1'b0, d | 16'h0010};
		else
			lanes_used = {1'b1, d};
	endfunction

	assign lane_en_status = lanes_used(r.mode, r.cs_sel, r.clk4) & r.oemask;

	// Lanes that may carry input data; the relocated clock is left out except in dual and quad with the second select
	logic [16:0] lk_rx_lanes; // Receive lanes, bit 16 unused here
	assign lk_rx_lanes = lanes_used(lk_mode, lk_cs, 1'b0);

	// Link next-state: synchronise config, capture inputs
	always_comb
	begin
		next_l = l;
		// Configuration crossing, first stage read only by the second
		next_l.sync1 = cfg_word;
		next_l.sync2 = l.sync1;
		next_l.sync3 = l.sync2;
		// Adopt only a word that held still over two samples
		if (l.sync2 == l.sync3)
			next_l.cfg = l.sync3;
		// Pad input synchronisers
		next_l.pad_s1 = data_pad_in;
		next_l.pad_s2 = l.pad_s1;
		next_l.strb_s1 = {high_data_strobe_in, low_data_strobe_in};
		next_l.strb_s2 = l.strb_s1;
		next_l.din = 16'h0000;
		if (lk_mode == 3'(mlspm_single))
		begin
			// Input arrives on lane 1 or lane 5
			if (lk_sepio)
				next_l.din[0] = lk_cs ? l.pad_s2[5] : l.pad_s2[1];
			else
				next_l.din[1] = lk_cs ? l.pad_s2[5] : l.pad_s2[1];
		end
		else
			next_l.din = l.pad_s2 & lk_rx_lanes[15:0];
		next_l.strb = l.strb_s2;
	end

	// Link register update
	always_ff @(posedge link_clk or negedge rst_b)
	begin
		if (!rst_b)
			l <= '0;
		else
			l <= next_l;
	end

	////////////////////////////////////////////////////////////////////////
	// Pad drive in the link domain
	logic [16:0] lk_used;  // Enabled lanes and clock pad
	logic [15:0] lk_src;   // Controller lanes steered to pads
	logic        lk_reloc; // Clock moved to lane four
	assign lk_used = lanes_used(lk_mode, lk_cs, lk_clk4) & lk_mask;
	assign lk_reloc = lk_clk4 && lk_mode < 3'(mlspm_octal);

	// Steer controller lanes: second select shifts narrow lanes up by four
	always_comb
	begin
		lk_src = core_dout;
		if (lk_cs && lk_mode < 3'(mlspm_octal))
			lk_src = {core_dout[11:0], 4'h0};
		if (lk_reloc)
			lk_src[`MLSPM_LANE_FOUR] = core_sck;
	end

	// Data pad outputs and enables
	always_comb
	begin
		logic [15:0] oe_src;
		oe_src = (lk_cs && lk_mode < 3'(mlspm_octal)) ? {core_doe[11:0], 4'h0}
			: core_doe;
		if (lk_mode == 3'(mlspm_single))
			oe_src = lk_cs ? 16'h0010 : 16'h0001;
		if (lk_reloc)
			oe_src[`MLSPM_LANE_FOUR] = 1'b1;
		data_pad_out = lk_src & lk_used[15:0];
		data_pad_oe = oe_src & lk_used[15:0];
	end

	// Clock and chip selects
	assign clk_pad_out = core_sck & lk_used[`MLSPM_CLK_PAD_BIT + 8];
	assign clk_pad_oe = lk_used[16];
	assign first_chip_select_b = !(core_cs_active && !lk_cs);
	assign second_chip_select_b = !(core_cs_active && lk_cs);

	// Strobes: low for octal and hex, high for hex only
	logic strb_lo_en; // Low strobe lane in use
	logic strb_hi_en; // High strobe lane in use
	assign strb_lo_en = lk_mode >= 3'(mlspm_octal);
	assign strb_hi_en = lk_mode == 3'(mlspm_hex);
	assign low_data_strobe_out = core_strobe_out[0] & strb_lo_en;
	assign low_data_strobe_oe = core_strobe_oe & strb_lo_en;
	assign high_data_strobe_out = core_strobe_out[1] & strb_hi_en;
	assign high_data_strobe_oe = core_strobe_oe & strb_hi_en;

	// Received data back to the controller
	assign core_din = l.din;
	assign core_strobe_in = l.strb & {strb_hi_en, strb_lo_en};

endmodule
`default_nettype wire

// ---- core/mlspm_params.svh ----
// Purpose: Constants for the multi-lane SPI pad map
// Assumes: Included by bare name from the design and the bench
// Notes:   Register map is reached over the plain register port
`ifndef MLSPM_PARAMS_SVH
`define MLSPM_PARAMS_SVH

// Register offsets (byte addresses)
`define MLSPM_ADDR_CFG      8'h00
`define MLSPM_ADDR_OEMASK   8'h04
`define MLSPM_ADDR_STATUS   8'h08

// Configuration register fields
`define MLSPM_CFG_MODE_LSB  0
`define MLSPM_CFG_MODE_MSB  2
`define MLSPM_CFG_CS_BIT    3
`define MLSPM_CFG_CLK4_BIT  4
`define MLSPM_CFG_SEPIO_BIT 5

// Reset values
`define MLSPM_CFG_RST       32'h0000_0000
`define MLSPM_OEMASK_RST    32'h0000_0000

// Base for the clock pad mask bit, which sits 8 above it at bit 16
`define MLSPM_CLK_PAD_BIT   8
`define MLSPM_LANE_FOUR     4

`endif

// ---- core/mlspm_pkg.sv ----
// Purpose: Types for the multi-lane SPI pad map
// Assumes: Constants come from the params header
// Notes:   Mode encoding is shared with the verification side
package mlspm_pkg;
	// Bus width configurations
	typedef enum logic [2:0]
	{
		mlspm_single,
		mlspm_dual,
		mlspm_quad,
		mlspm_octal,
		mlspm_hex
	} mlspm_mode_t;
endpackage

// ---- tb/mlspm_monitor.sv ----
// Purpose: Port checks for the pad map
// Assumes: All checks sampled on the link clock
// Notes:   Bound to the top module
`timescale 1ns/100ps
`default_nettype none
module mlspm_monitor #(parameter int INSTANCE = 0)
(
	// Clock and reset
	input wire logic        link_clk,
	input wire logic        rst_b,
	// Controller side
	input wire logic        core_sck,
	input wire logic        core_cs_active,
	input wire logic [15:0] core_dout,
	input wire logic [1:0]  core_strobe_out,
	// Pads
	input wire logic        first_chip_select_b,
	input wire logic        second_chip_select_b,
	input wire logic        clk_pad_out,
	input wire logic        clk_pad_oe,
	input wire logic [15:0] data_pad_out,
	input wire logic [15:0] data_pad_oe,
	input wire logic        low_data_strobe_out,
	input wire logic        low_data_strobe_oe,
	input wire logic        high_data_strobe_out,
	input wire logic        high_data_strobe_oe
);
	default clocking cb @(posedge link_clk); endclocking
	default disable iff (!rst_b);
	// Pads released for two cycles after reset
	sequence quiet_s;
		(data_pad_oe == 16'h0 && !clk_pad_oe) [*2];
	endsequence
	AST_RESET_QUIET: assert property ($rose(rst_b) |-> quiet_s)
		else $error("pads driven after reset");
	AST_CS_EXCL: assert property (first_chip_select_b || second_chip_select_b)
		else $error("both selects low");
	AST_CS_IDLE: assert property (!core_cs_active |-> first_chip_select_b && second_chip_select_b)
		else $error("select low while idle");
	AST_CLK_PAD: assert property (clk_pad_oe |-> clk_pad_out == core_sck)
		else $error("clock pad wrong");
	AST_HEX_INST: assert property (|data_pad_oe[15:8] || high_data_strobe_oe |-> INSTANCE == 0 || INSTANCE == 3)
		else $error("upper lanes on narrow instance");
	AST_HEX_OUT: assert property (data_pad_oe[15:8] == 8'hff |-> data_pad_out[15:8] == core_dout[15:8])
		else $error("upper lane data wrong");
	AST_LO_STROBE: assert property (low_data_strobe_oe |-> low_data_strobe_out == core_strobe_out[0])
		else $error("low strobe wrong");
	AST_HI_STROBE: assert property (high_data_strobe_oe |-> high_data_strobe_out == core_strobe_out[1])
		else $error("high strobe wrong");
endmodule
bind mlspm_pad_map mlspm_monitor #(.INSTANCE(INSTANCE)) i_mlspm_monitor (.link_clk, .rst_b,
	.core_sck, .core_cs_active, .core_dout, .core_strobe_out, .first_chip_select_b,
	.second_chip_select_b, .clk_pad_out, .clk_pad_oe, .data_pad_out, .data_pad_oe,
	.low_data_strobe_out, .low_data_strobe_oe, .high_data_strobe_out, .high_data_strobe_oe);
`default_nettype wire

// ---- tb/mlspm_flash_model.sv ----
// Purpose: Far-side memory model
// Assumes: Driven lanes echo back
// Notes:   Released lanes carry a reply, inverted while deselected
`timescale 1ns/100ps
`default_nettype none
module mlspm_flash_model #(parameter logic [15:0] RESP = 16'ha5c3)
(
	// From the device
	input wire logic        sel0_b,
	input wire logic        sel1_b,
	input wire logic [15:0] pad_out,
	input wire logic [15:0] pad_oe,
	// To the device
	output logic     [15:0] pad_in,
	output logic            strobe_lo,
	output logic            strobe_hi
);
	// Wire level from both drivers
	always_comb
	begin
		pad_in = (pad_out & pad_oe) | ((sel0_b && sel1_b ? ~RESP : RESP) & ~pad_oe);
		strobe_lo = RESP[0];
		strobe_hi = RESP[15];
	end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Directed bench for the pad map
// Assumes: Instance zero, hex capable
// Notes:   Registers reached over the plain port
`timescale 1ns/100ps
`default_nettype none
`include "mlspm_params.svh"
module tb;
	localparam logic [15:0] RESP = 16'ha5c3;
	logic        clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
	logic [7:0]  reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic        core_sck = 1'b0, core_cs_active = 1'b0, core_strobe_oe = 1'b1;
	logic [15:0] core_dout = 16'h3c96, core_doe = 16'hffff, core_din;
	logic [15:0] data_pad_in, data_pad_out, data_pad_oe;
	logic [1:0]  core_strobe_out = 2'h2, core_strobe_in;
	logic        first_chip_select_b, second_chip_select_b, clk_pad_out, clk_pad_oe;
	logic        low_data_strobe_in, low_data_strobe_out, low_data_strobe_oe;
	logic        high_data_strobe_in, high_data_strobe_out, high_data_strobe_oe;
	int          bad_count = 0, checks = 0;
	always #25 clk = ~clk;
	// Link clock offset so edges never meet
	initial
	begin
		#7;
		forever #15 link_clk = ~link_clk;
	end
	mlspm_pad_map #(.INSTANCE(0)) i_mlspm_pad_map (.clk, .rst_b, .link_clk, .reg_addr,
		.reg_wdata, .reg_write, .reg_read, .reg_rdata, .core_sck, .core_cs_active, .core_dout,
		.core_doe, .core_din, .core_strobe_out, .core_strobe_oe, .core_strobe_in,
		.first_chip_select_b, .second_chip_select_b, .clk_pad_out, .clk_pad_oe, .data_pad_in,
		.data_pad_out, .data_pad_oe, .low_data_strobe_in, .low_data_strobe_out,
		.low_data_strobe_oe, .high_data_strobe_in, .high_data_strobe_out, .high_data_strobe_oe);
	mlspm_flash_model #(.RESP(RESP)) i_mlspm_flash_model (.sel0_b(first_chip_select_b),
		.sel1_b(second_chip_select_b), .pad_out(data_pad_out), .pad_oe(data_pad_oe),
		.pad_in(data_pad_in), .strobe_lo(low_data_strobe_in), .strobe_hi(high_data_strobe_in));
	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] seen);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 cmp("reg_rdata", exp, reg_rdata);
		@(posedge clk);
	endtask
	// Program mask and mode, then let the crossing and pad sampling settle
	task automatic cfg(input logic [31:0] c, input logic [31:0] m);
		wr(`MLSPM_ADDR_OEMASK, m);
		wr(`MLSPM_ADDR_CFG, c);
		repeat (8) @(posedge link_clk);
		@(posedge clk);
	endtask
	function automatic logic [15:0] lanes(input int m, input int s);
		logic [15:0] w;
		w = (m == 4) ? 16'hffff : (m == 3) ? 16'h00ff : (16'h1 << (1 << m)) - 16'h1;
		return (s != 0 && m < 3) ? w << 4 : w;
	endfunction
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(`MLSPM_ADDR_CFG, `MLSPM_CFG_RST);
		rd(`MLSPM_ADDR_OEMASK, `MLSPM_OEMASK_RST);
		rd(8'h0c, 32'h0);
		cmp("data_pad_oe", 32'h0, data_pad_oe);
		core_cs_active <= 1'b1;
		for (int m = 0; m < 5; m++)
			for (int s = 0; s < 2; s++)
			begin
				cfg(32'(m | (s << 3)), 32'h1ffff);
				cmp("data_pad_oe", lanes(m, s), data_pad_oe);
				cmp("selects", s ? 2'b10 : 2'b01, {first_chip_select_b, second_chip_select_b});
				cmp("clk_pad_oe", 32'h1, clk_pad_oe);
				cmp("strobe oe", {m == 4, m >= 3}, {high_data_strobe_oe, low_data_strobe_oe});
				cmp("core_strobe_in", {m == 4 && RESP[15], m >= 3 && RESP[0]}, core_strobe_in);
				rd(`MLSPM_ADDR_CFG, 32'(m | (s << 3)));
				rd(`MLSPM_ADDR_STATUS, {15'h0, 1'b1, lanes(m, s)});
				$display("test mode %0d select %0d done", m, s);
			end
		cmp("core_din", core_dout, core_din);
		cfg(32'h12, 32'h1f);
		cmp("data_pad_oe", 32'h1f, data_pad_oe);
		core_sck <= 1'b1;
		@(posedge clk);
		cmp("lane four clock", 2'b01, {clk_pad_oe, data_pad_out[4]});
		cfg(32'h13, 32'h1ffff);
		cmp("clk_pad_oe", 32'h1, clk_pad_oe);
		$display("test clock relocation done");
		cfg(32'h20, 32'h1ffff);
		cmp("core_din0", RESP[1], core_din[0]);
		cfg(32'h28, 32'h1ffff);
		cmp("core_din0", RESP[5], core_din[0]);
		cfg(32'h0, 32'h1ffff);
		cmp("core_din", {RESP[1], 1'b0}, core_din);
		wr(`MLSPM_ADDR_CFG, 32'h7);
		rd(`MLSPM_ADDR_CFG, 32'h0);
		cfg(32'h4, 32'h0);
		cmp("masked oe", 32'h0, {clk_pad_oe, data_pad_oe});
		$display("test separate io and mask done");
		summarize();
	end
	// Watchdog well beyond the expected run
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		summarize();
	end
endmodule
`default_nettype wire
